/* verilog/tws_defs.vh */
`ifndef TWS_DEFS_VH
`define TWS_DEFS_VH
`define TWS_OFF_DATA   5'h00
`define TWS_OFF_STAT   5'h04
`define TWS_OFF_CST    5'h08
`define TWS_OFF_CTL1   5'h0c
`define TWS_OFF_CTL2   5'h10
`define TWS_OFF_OWN    5'h14
`define TWS_C1_START   0
`define TWS_C1_STOP    1
`define TWS_C1_IRQ_ENABLE   2
`define TWS_C1_ACK     4
`define TWS_C1_GCEN    5
`define TWS_C1_NEW_MATCH_IRQ_ENABLE  6
`define TWS_C1_STALL_AFTER_START_ENABLE 7
`define TWS_ST_NEW_ADDRESS_MATCH  2
`define TWS_ST_STALL_AFTER_START_FLAG  3
`define TWS_ST_NACK_RECEIVED  4
`define TWS_ST_BER     5
`define TWS_ST_SLAVE_STOP_SEEN  7
`define TWS_CST_BB     1
`define TWS_OWN_SLAVE_ADDRESS_ENABLE   7
`define TWS_RST_BYTE   8'h00
`define TWS_GC_ADDR    8'h00
`define TWS_RESP_OK    2'b00
`define TWS_RESP_ERR   2'b10
`define TWS_MS_IDLE    3'h0
`define TWS_MS_START   3'h1
`define TWS_MS_LOW     3'h2
`define TWS_MS_HIGH    3'h3
`define TWS_MS_PREP    3'h4
`define TWS_MS_RISE    3'h5
`endif

/* verilog/tws_sync.v */
`timescale 1ns/10ps
// two-stage synchroniser, idles high like the bus lines
module tws_sync (
    input  wire aclk,
    input  wire aresetn,
    input  wire d,
    output wire q
);
    reg meta_ff;
    reg sync_ff;

    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            meta_ff <= 1'b1;
            sync_ff <= 1'b1;
        end
        else
        begin
            meta_ff <= d;
            sync_ff <= meta_ff;
        end
    end

    assign q = sync_ff;
endmodule // tws_sync

/* verilog/tws_unit.v */
// Added by the designer: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
`include "tws_defs.vh"
module tws_unit (
    input  wire        aclk,
    input  wire        aresetn,
    input  wire [4:0]  awaddr,
    input  wire        awvalid,
    output wire        awready,
    input  wire [31:0] wdata,
    input  wire [3:0]  wstrb,
    input  wire        wvalid,
    output wire        wready,
    output wire [1:0]  bresp,
    output wire        bvalid,
    input  wire        bready,
    input  wire [4:0]  araddr,
    input  wire        arvalid,
    output wire        arready,
    output wire [31:0] rdata,
    output wire [1:0]  rresp,
    output wire        rvalid,
    input  wire        rready,
    input  wire        scl_i,
    output wire        scl_o,
    output wire        scl_oe_n,
    input  wire        sda_i,
    output wire        sda_o,
    output wire        sda_oe_n,
    input  wire        low_power,
    output wire        wakeup,
    output wire        irq
);
    reg [7:0] shift_ff;
    reg       transmit_direction_ff, master_ff, new_address_match_ff, stall_after_start_flag_ff;
    reg       nack_received_ff, ber_ff, buffer_attention_ff, slave_stop_seen_ff;
    reg       start_req_ff, stop_req_ff, irq_enable_ff, ack_ctl_ff;
    reg       gcen_ff, new_match_irq_enable_ff, stall_after_start_enable_ff;
    reg [6:0] div_ff;
    reg       enable_ff;
    reg [6:0] own_ff;
    reg       slave_address_enable_ff;
    reg       match_ff, general_call_hit_ff, bb_ff;
    reg [3:0] cnt_ff;
    reg       active_ff, addr_ph_ff, wake_nack_ff, wakeup_ff;
    reg       d_sda_ff, m_sda_ff, m_scl_ff, stretch_ff, rs_arm_ff;
    reg [2:0] ms_ff;
    reg [7:0] tmr_ff;
    reg       scl_q_ff, sda_q_ff, sda_oe_n_ff, scl_oe_n_ff;
    reg       bvalid_ff, rvalid_ff;
    reg [1:0] bresp_ff, rresp_ff;
    reg [7:0] rdata_ff;
    reg [7:0] rd_byte;
    reg       r_hit, w_hit;
    wire      scl_s, sda_s;
    wire [7:0] addr_byte;
    wire      hit_own, hit_gc;

    tws_sync u_scl_sync (
        .aclk    (aclk),
        .aresetn (aresetn),
        .d       (scl_i),
        .q       (scl_s)
    );
    tws_sync u_sda_sync (
        .aclk    (aclk),
        .aresetn (aresetn),
        .d       (sda_i),
        .q       (sda_s)
    );

    wire scl_rise  = scl_s & ~scl_q_ff;
    wire scl_fall  = ~scl_s & scl_q_ff;
    wire start_det = scl_s & scl_q_ff & sda_q_ff & ~sda_s;
    wire stop_det  = scl_s & scl_q_ff & ~sda_q_ff & sda_s;
    wire inv       = master_ff | match_ff | general_call_hit_ff;
    // counts 2..8 are bits 2..8, 9 is the high half of the acknowledge
    wire illegal   = active_ff & (cnt_ff > 4'h1) & inv;
    wire tx_now    = (master_ff & addr_ph_ff) | (inv & transmit_direction_ff);
    wire stall_m   = buffer_attention_ff | nack_received_ff | stall_after_start_flag_ff;
    wire busy      = (start_req_ff & ~master_ff) | inv
                   | (active_ff & addr_ph_ff);
    wire [7:0] half_m1 = {div_ff, 1'b0} - 8'h01;
    wire [7:0] status  = {slave_stop_seen_ff, buffer_attention_ff, ber_ff, nack_received_ff,
                          stall_after_start_flag_ff, new_address_match_ff, master_ff, transmit_direction_ff};
    wire [7:0] cst     = {3'h0, sda_s, general_call_hit_ff, match_ff, bb_ff, busy};
    wire [7:0] ctl1    = {stall_after_start_enable_ff, new_match_irq_enable_ff, gcen_ff, ack_ctl_ff, 1'b0,
                          irq_enable_ff, stop_req_ff, start_req_ff};

    assign addr_byte = {shift_ff[6:0], sda_s};
    assign hit_own   = slave_address_enable_ff & (addr_byte[7:1] == own_ff);
    assign hit_gc    = gcen_ff & (addr_byte == `TWS_GC_ADDR);

    // bus slave handshake
    wire wr_go = awvalid & wvalid & ~bvalid_ff;
    wire rd_go = arvalid & ~rvalid_ff;
    wire w_en  = wr_go & wstrb[0];
    wire [7:0] wb = wdata[7:0];
    wire wr_data = w_en & (awaddr == `TWS_OFF_DATA);
    wire wr_stat = w_en & (awaddr == `TWS_OFF_STAT);
    wire wr_cst  = w_en & (awaddr == `TWS_OFF_CST);
    wire wr_ctl1 = w_en & (awaddr == `TWS_OFF_CTL1);
    wire wr_ctl2 = w_en & (awaddr == `TWS_OFF_CTL2);
    wire wr_own  = w_en & (awaddr == `TWS_OFF_OWN);
    wire rd_data = rd_go & (araddr == `TWS_OFF_DATA);

    assign awready = wr_go;
    assign wready  = wr_go;
    assign bvalid  = bvalid_ff;
    assign bresp   = bresp_ff;
    assign arready = ~rvalid_ff;
    assign rvalid  = rvalid_ff;
    assign rresp   = rresp_ff;
    assign rdata   = {24'h000000, rdata_ff};

    always @*
    begin
        w_hit = (awaddr == `TWS_OFF_DATA) | (awaddr == `TWS_OFF_STAT)
              | (awaddr == `TWS_OFF_CST) | (awaddr == `TWS_OFF_CTL1)
              | (awaddr == `TWS_OFF_CTL2) | (awaddr == `TWS_OFF_OWN);
        r_hit = 1'b1;
        case (araddr)
            `TWS_OFF_DATA: rd_byte = shift_ff;
            `TWS_OFF_STAT: rd_byte = status;
            `TWS_OFF_CST:  rd_byte = cst;
            `TWS_OFF_CTL1: rd_byte = ctl1;
            `TWS_OFF_CTL2: rd_byte = {div_ff, enable_ff};
            `TWS_OFF_OWN:  rd_byte = {slave_address_enable_ff, own_ff};
            default:
            begin
                rd_byte = 8'h00;
                r_hit   = 1'b0;
            end
        endcase
    end

    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            bvalid_ff <= 1'b0;
            bresp_ff  <= `TWS_RESP_OK;
            rvalid_ff <= 1'b0;
            rresp_ff  <= `TWS_RESP_OK;
            rdata_ff  <= 8'h00;
        end
        else
        begin
            if (wr_go)
            begin
                bvalid_ff <= 1'b1;
                bresp_ff  <= w_hit ? `TWS_RESP_OK : `TWS_RESP_ERR;
            end
            else if (bready)
                bvalid_ff <= 1'b0;
            if (rd_go)
            begin
                rvalid_ff <= 1'b1;
                rdata_ff  <= rd_byte;
                rresp_ff  <= r_hit ? `TWS_RESP_OK : `TWS_RESP_ERR;
            end
            else if (rready)
                rvalid_ff <= 1'b0;
        end
    end

    // divider, enable and own address survive disable
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            div_ff    <= 7'h00;
            enable_ff <= 1'b0;
            own_ff    <= 7'h00;
            slave_address_enable_ff   <= 1'b0;
        end
        else
        begin
            if (wr_ctl2)
            begin
                div_ff    <= wb[7:1];
                enable_ff <= wb[0];
            end
            if (wr_own)
            begin
                own_ff  <= wb[6:0];
                slave_address_enable_ff <= wb[`TWS_OWN_SLAVE_ADDRESS_ENABLE];
            end
        end
    end

    // protocol engine; clears on reset and while disabled
    always @(posedge aclk)
    begin
        if (!aresetn || !enable_ff)
        begin
            shift_ff <= `TWS_RST_BYTE;
            {transmit_direction_ff, master_ff, new_address_match_ff, stall_after_start_flag_ff} <= 4'h0;
            {nack_received_ff, ber_ff, buffer_attention_ff, slave_stop_seen_ff} <= 4'h0;
            {start_req_ff, stop_req_ff, irq_enable_ff, ack_ctl_ff} <= 4'h0;
            {gcen_ff, new_match_irq_enable_ff, stall_after_start_enable_ff} <= 3'h0;
            {match_ff, general_call_hit_ff, bb_ff} <= 3'h0;
            cnt_ff <= 4'h0;
            {active_ff, addr_ph_ff, wake_nack_ff, wakeup_ff} <= 4'h0;
            {d_sda_ff, m_sda_ff, m_scl_ff, stretch_ff, rs_arm_ff} <= 5'h00;
            ms_ff <= `TWS_MS_IDLE;
            tmr_ff <= 8'h00;
            scl_q_ff <= 1'b1;
            sda_q_ff <= 1'b1;
        end
        else
        begin
            wakeup_ff <= 1'b0;
            scl_q_ff  <= scl_s;
            sda_q_ff  <= sda_s;
            if (stop_det)
                bb_ff <= 1'b0;
            else if (start_det || !scl_s || !sda_s)
                bb_ff <= 1'b1;
            else if (wr_cst && wb[`TWS_CST_BB])
                bb_ff <= 1'b0;
            // software side: clears first so hardware sets win
            if (wr_ctl1)
                {stall_after_start_enable_ff, new_match_irq_enable_ff, gcen_ff, ack_ctl_ff, irq_enable_ff,
                 stop_req_ff, start_req_ff} <= {wb[7:4], wb[2:0]};
            if (wr_stat)
            begin
                if (wb[`TWS_ST_NEW_ADDRESS_MATCH]) new_address_match_ff <= 1'b0;
                if (wb[`TWS_ST_STALL_AFTER_START_FLAG]) stall_after_start_flag_ff <= 1'b0;
                if (wb[`TWS_ST_NACK_RECEIVED]) nack_received_ff <= 1'b0;
                if (wb[`TWS_ST_BER])    ber_ff    <= 1'b0;
                if (wb[`TWS_ST_SLAVE_STOP_SEEN]) slave_stop_seen_ff <= 1'b0;
            end
            if (wr_ctl1 ? !wb[`TWS_C1_STALL_AFTER_START_ENABLE] : !stall_after_start_enable_ff)
                stall_after_start_flag_ff <= 1'b0;
            if (wr_data)
            begin
                shift_ff <= wb;
                if (start_req_ff && master_ff)
                    rs_arm_ff <= 1'b1;
                else if (tx_now)
                begin
                    buffer_attention_ff <= 1'b0;
                    d_sda_ff <= ~wb[7];
                end
            end
            if (rd_data && !transmit_direction_ff && !start_req_ff)
                buffer_attention_ff <= 1'b0;
            // start and stop seen on the lines
            if (start_det)
            begin
                if (illegal)
                begin
                    ber_ff    <= 1'b1;
                    master_ff <= 1'b0;
                end
                {match_ff, general_call_hit_ff} <= 2'b00;
                active_ff  <= 1'b1;
                addr_ph_ff <= 1'b1;
                cnt_ff     <= 4'h0;
                if (!master_ff)
                    transmit_direction_ff <= 1'b0;
                if (low_power)
                begin
                    wakeup_ff    <= 1'b1;
                    wake_nack_ff <= 1'b1;
                end
            end
            else if (stop_det)
            begin
                if (illegal)
                    ber_ff <= 1'b1;
                if (match_ff || general_call_hit_ff)
                    slave_stop_seen_ff <= 1'b1;
                {match_ff, general_call_hit_ff} <= 2'b00;
                master_ff   <= 1'b0;
                active_ff   <= 1'b0;
                transmit_direction_ff     <= 1'b0;
                d_sda_ff    <= 1'b0;
                stop_req_ff <= 1'b0;
            end
            else if (scl_rise && active_ff)
            begin
                shift_ff <= addr_byte;
                cnt_ff   <= cnt_ff + 4'h1;
                if (master_ff && tx_now && cnt_ff != 4'h8
                    && !d_sda_ff && !m_sda_ff && !sda_s)
                begin
                    ber_ff       <= 1'b1;
                    master_ff    <= 1'b0;
                    start_req_ff <= 1'b0;
                    transmit_direction_ff      <= 1'b0;
                    d_sda_ff     <= 1'b0;
                end
                if (cnt_ff == 4'h7 && addr_ph_ff)
                begin
                    if (master_ff)
                        transmit_direction_ff <= ~addr_byte[0];
                    else if (!wake_nack_ff && (hit_own || hit_gc))
                    begin
                        match_ff  <= hit_own;
                        general_call_hit_ff <= hit_gc;
                        new_address_match_ff <= 1'b1;
                        transmit_direction_ff   <= addr_byte[0];
                    end
                end
                else if (cnt_ff == 4'h7 && inv && !transmit_direction_ff)
                    buffer_attention_ff <= 1'b1;
                if (cnt_ff == 4'h8)
                begin
                    addr_ph_ff   <= 1'b0;
                    wake_nack_ff <= 1'b0;
                    if (!transmit_direction_ff && !addr_ph_ff)
                        ack_ctl_ff <= 1'b0;
                    if (master_ff && addr_ph_ff)
                    begin
                        if (sda_s)
                            nack_received_ff <= 1'b1;
                        else if (stall_after_start_enable_ff)
                            stall_after_start_flag_ff <= 1'b1;
                        else if (transmit_direction_ff)
                            buffer_attention_ff <= 1'b1;
                    end
                    else if (inv && transmit_direction_ff)
                    begin
                        if (sda_s)
                            nack_received_ff <= 1'b1;
                        else
                            buffer_attention_ff <= 1'b1;
                    end
                end
            end
            else if (scl_fall && active_ff)
            begin
                if (cnt_ff == 4'h9)
                    cnt_ff <= 4'h0;
                if (cnt_ff == 4'h8)
                    d_sda_ff <= (!master_ff && addr_ph_ff
                                 && (match_ff || general_call_hit_ff))
                              | (inv && !transmit_direction_ff && !addr_ph_ff
                                 && !ack_ctl_ff);
                else
                    d_sda_ff <= tx_now && !buffer_attention_ff && !shift_ff[7];
            end
            // slave clock stretching
            stretch_ff <= (buffer_attention_ff || (new_address_match_ff && new_match_irq_enable_ff))
                        && !master_ff && inv && (stretch_ff || !scl_s);
            // master clock and start/stop generation
            if (ms_ff != `TWS_MS_IDLE && ms_ff != `TWS_MS_START
                && !master_ff && ms_ff != `TWS_MS_RISE)
            begin
                m_scl_ff <= 1'b0;
                m_sda_ff <= 1'b0;
                ms_ff    <= `TWS_MS_IDLE;
            end
            else
            begin
                case (ms_ff)
                    `TWS_MS_IDLE:
                    begin
                        m_scl_ff <= 1'b0;
                        m_sda_ff <= 1'b0;
                        if (start_req_ff && !bb_ff && !low_power
                            && !master_ff)
                        begin
                            m_sda_ff <= 1'b1;
                            tmr_ff   <= half_m1;
                            ms_ff    <= `TWS_MS_START;
                        end
                    end
                    `TWS_MS_START:
                    begin
                        if (!scl_s)
                        begin
                            ber_ff       <= 1'b1;
                            start_req_ff <= 1'b0;
                            m_sda_ff     <= 1'b0;
                            ms_ff        <= `TWS_MS_IDLE;
                        end
                        else if (tmr_ff == 8'h00)
                        begin
                            m_scl_ff     <= 1'b1;
                            m_sda_ff     <= 1'b0;
                            tmr_ff       <= half_m1;
                            start_req_ff <= 1'b0;
                            transmit_direction_ff      <= 1'b1;
                            if (master_ff)
                                d_sda_ff <= ~shift_ff[7];
                            else
                            begin
                                d_sda_ff  <= 1'b1;
                                master_ff <= 1'b1;
                                buffer_attention_ff  <= 1'b1;
                            end
                            ms_ff <= `TWS_MS_LOW;
                        end
                        else
                            tmr_ff <= tmr_ff - 8'h01;
                    end
                    `TWS_MS_LOW:
                    begin
                        m_scl_ff <= 1'b1;
                        if (tmr_ff != 8'h00)
                            tmr_ff <= tmr_ff - 8'h01;
                        else if (rs_arm_ff || (stop_req_ff && stall_m))
                        begin
                            d_sda_ff <= 1'b0;
                            m_sda_ff <= ~rs_arm_ff;
                            tmr_ff   <= half_m1;
                            ms_ff    <= `TWS_MS_PREP;
                        end
                        else if (!stall_m)
                        begin
                            m_scl_ff <= 1'b0;
                            tmr_ff   <= half_m1;
                            ms_ff    <= `TWS_MS_HIGH;
                        end
                    end
                    `TWS_MS_HIGH:
                    begin
                        if (scl_s ? tmr_ff == 8'h00 : tmr_ff != half_m1)
                        begin
                            m_scl_ff <= 1'b1;
                            tmr_ff   <= half_m1;
                            ms_ff    <= `TWS_MS_LOW;
                        end
                        else if (scl_s)
                            tmr_ff <= tmr_ff - 8'h01;
                    end
                    `TWS_MS_PREP:
                    begin
                        if (tmr_ff == 8'h00)
                        begin
                            m_scl_ff <= 1'b0;
                            tmr_ff   <= half_m1;
                            ms_ff    <= `TWS_MS_RISE;
                        end
                        else
                            tmr_ff <= tmr_ff - 8'h01;
                    end
                    `TWS_MS_RISE:
                    begin
                        if (scl_s && tmr_ff == 8'h00)
                        begin
                            m_sda_ff  <= rs_arm_ff;
                            rs_arm_ff <= 1'b0;
                            tmr_ff    <= half_m1;
                            ms_ff     <= rs_arm_ff ? `TWS_MS_START
                                                   : `TWS_MS_IDLE;
                        end
                        else if (scl_s)
                            tmr_ff <= tmr_ff - 8'h01;
                    end
                    default:
                        ms_ff <= `TWS_MS_IDLE;
                endcase
            end
        end
    end

    // open-drain pins: only ever pulled low
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            sda_oe_n_ff <= 1'b1;
            scl_oe_n_ff <= 1'b1;
        end
        else
        begin
            sda_oe_n_ff <= ~(d_sda_ff | m_sda_ff);
            scl_oe_n_ff <= ~(m_scl_ff | stretch_ff);
        end
    end

    assign sda_o    = 1'b0;
    assign scl_o    = 1'b0;
    assign sda_oe_n = sda_oe_n_ff;
    assign scl_oe_n = scl_oe_n_ff;
    assign wakeup   = wakeup_ff;
    assign irq = irq_enable_ff & ((new_address_match_ff & new_match_irq_enable_ff) | ber_ff
               | nack_received_ff | buffer_attention_ff | stall_after_start_flag_ff | slave_stop_seen_ff);
endmodule // tws_unit

/* sim/tws_chk.sv */
`timescale 1ns/10ps
module tws_chk (
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        awvalid,
    input wire logic        wvalid,
    input wire logic        awready,
    input wire logic        bvalid,
    input wire logic        bready,
    input wire logic        arvalid,
    input wire logic        rvalid,
    input wire logic        rready,
    input wire logic [31:0] rdata,
    input wire logic        scl_o,
    input wire logic        sda_o,
    input wire logic        scl_oe_n,
    input wire logic        sda_oe_n,
    input wire logic        sda_i,
    input wire logic        low_power,
    input wire logic        wakeup
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence wr_take; awvalid && wvalid && !bvalid; endsequence
    sequence rd_take; arvalid && !rvalid; endsequence
    a_pins_open_drain: assert property (scl_o == 1'b0 && sda_o == 1'b0)
        else $error("bus pin driven high");
    a_pins_reset_free: assert property (disable iff (1'b0)
        !aresetn |=> scl_oe_n && sda_oe_n)
        else $error("bus pin pulled after reset");
    a_wake_pulse: assert property (wakeup |=> !wakeup)
        else $error("wake pulse longer than one cycle");
    a_wake_on_start: assert property (wakeup |-> $past(low_power) && !sda_i)
        else $error("wake without start in low power");
    a_write_answer: assert property (wr_take |=> bvalid)
        else $error("write not answered");
    a_read_answer: assert property (rd_take |=> rvalid && rdata[31:8] == 24'h0)
        else $error("read answer late or wide");
    a_write_ready: assert property (awready == (awvalid && wvalid && !bvalid))
        else $error("write ready wrong");
    a_write_done: assert property (bvalid && bready |=> !bvalid)
        else $error("write response stuck");
    a_read_done: assert property (rvalid && rready |=> !rvalid)
        else $error("read response stuck");
endmodule // tws_chk
bind tws_unit tws_chk tws_chk_i (.*);

/* sim/tws_bfm.sv */
`timescale 1ns/10ps
module tws_bfm (
    input  wire logic aclk,
    input  wire logic scl_w,
    input  wire logic sda_w,
    output logic      m_scl,
    output logic      m_sda
);
    int hung = 0;
    initial m_scl = 1'b1;
    initial m_sda = 1'b1;
    task automatic hp;
        repeat (40) @(posedge aclk);
    endtask
    // release scl, then wait out any stretch by the slave
    task automatic rise;
        int n;
        n = 0;
        m_scl <= 1'b1;
        do @(posedge aclk); while (scl_w !== 1'b1 && ++n < 5000);
        if (n >= 5000) hung++;
        hp();
    endtask
    // sda moves a few cycles after scl falls so no false start is seen
    task automatic bit_io(input logic b, output logic s);
        repeat (4) @(posedge aclk);
        m_sda <= b;
        hp();
        rise();
        s = sda_w;
        m_scl <= 1'b0;
    endtask
    task automatic start;
        m_sda <= 1'b1;
        hp();
        rise();
        m_sda <= 1'b0;
        hp();
        m_scl <= 1'b0;
    endtask
    task automatic stop;
        repeat (4) @(posedge aclk);
        m_sda <= 1'b0;
        hp();
        rise();
        m_sda <= 1'b1;
        hp();
    endtask
    task automatic xfer(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) bit_io(d[i], s);
        bit_io(1'b1, ack);
    endtask
endmodule // tws_bfm

/* sim/tws_unit_tb_top.sv */
`timescale 1ns/10ps
module tws_unit_tb_top;
    localparam int LIM = 4000;
    logic        aclk, aresetn, awvalid, wvalid, arvalid, low_power, ack;
    logic        awready, wready, bvalid, arready, rvalid, wakeup, irq;
    logic        scl_o, scl_oe_n, sda_o, sda_oe_n, m_scl, m_sda;
    logic [4:0]  awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [1:0]  bresp, rresp, r;
    logic [7:0]  d;
    int          errors = 0, tests_run = 0, n;
    wire         scl_w = (scl_oe_n | scl_o) & m_scl;
    wire         sda_w = (sda_oe_n | sda_o) & m_sda;
    tws_unit tws_unit_i (.wstrb(4'h1), .bready(1'b1), .rready(1'b1),
        .scl_i(scl_w), .sda_i(sda_w), .*);
    tws_bfm tws_bfm_i (.aclk(aclk), .scl_w(scl_w), .sda_w(sda_w),
        .m_scl(m_scl), .m_sda(m_sda));
    initial
    begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end
    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic check(input string nm, input logic [7:0] got, exp);
        tests_run++;
        if (got !== exp)
        begin
            errors++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask
    function automatic logic hit(input int k);
        case (k)
            0: return awready;
            1: return bvalid;
            2: return arready;
            3: return rvalid;
            4: return irq;
            5: return wakeup;
            default: return !sda_oe_n;
        endcase
    endfunction
    task automatic wt(input int k);
        int c;
        c = 0;
        do @(negedge aclk); while (hit(k) !== 1'b1 && ++c < LIM);
        check("handshake", {7'h0, c < LIM}, 8'h01);
        if (c >= LIM) tally_and_finish();
    endtask
    task automatic wr(input logic [4:0] a, input logic [7:0] v);
        awaddr <= a;
        wdata <= {24'h0, v};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        wt(0);
        @(posedge aclk);
        awvalid <= 1'b0;
        wvalid <= 1'b0;
        wt(1);
        check("write response", {6'h0, bresp}, 8'h00);
        @(posedge aclk);
    endtask
    task automatic rd(input logic [4:0] a);
        araddr <= a;
        arvalid <= 1'b1;
        wt(2);
        @(posedge aclk);
        arvalid <= 1'b0;
        wt(3);
        d = rdata[7:0];
        r = rresp;
        @(posedge aclk);
    endtask
    task automatic rdc(input logic [4:0] a, input logic [7:0] x);
        rd(a);
        check($sformatf("register %h", a), d, x);
    endtask
    initial
    begin
        {awvalid, wvalid, arvalid, low_power, aresetn} = 5'h00;
        {awaddr, araddr, wdata} = '0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        rdc(5'h04, 8'h00);
        rd(5'h18);
        check("unmapped", {6'h0, r}, 8'h02);
        wr(5'h14, 8'haa);
        wr(5'h10, 8'h11);
        wr(5'h0c, 8'h44);
        $display("register test done");
        fork
            begin
                tws_bfm_i.start();
                tws_bfm_i.xfer(8'h54, ack);
                check("address ack", {7'h0, ack}, 8'h00);
                tws_bfm_i.xfer(8'ha5, ack);
                check("data ack", {7'h0, ack}, 8'h00);
            end
            begin
                wt(4);
                check("irq", {7'h0, irq}, 8'h01);
                rdc(5'h04, 8'h04);
                wr(5'h04, 8'h00);
                rdc(5'h04, 8'h04);
                wr(5'h04, 8'h04);
                rdc(5'h04, 8'h00);
                n = 0;
                do rd(5'h04); while (d[6] !== 1'b1 && ++n < LIM);
                check("attention", {7'h0, d[6]}, 8'h01);
                if (n >= LIM) tally_and_finish();
                rdc(5'h00, 8'ha5);
            end
        join
        tws_bfm_i.stop();
        rdc(5'h04, 8'h80);
        wr(5'h04, 8'h80);
        $display("slave receive test done");
        wr(5'h0c, 8'h20);
        tws_bfm_i.start();
        tws_bfm_i.xfer(8'h00, ack);
        check("general call ack", {7'h0, ack}, 8'h00);
        tws_bfm_i.stop();
        rdc(5'h04, 8'h84);
        wr(5'h10, 8'h10);
        rdc(5'h04, 8'h00);
        wr(5'h10, 8'h11);
        $display("general call test done");
        tws_bfm_i.start();
        tws_bfm_i.xfer(8'haa, ack);
        check("foreign ack", {7'h0, ack}, 8'h01);
        tws_bfm_i.stop();
        rdc(5'h04, 8'h00);
        $display("foreign address test done");
        rd(5'h08);
        check("busy", {7'h0, d[0]}, 8'h00);
        low_power <= 1'b1;
        fork
            begin
                tws_bfm_i.start();
                tws_bfm_i.xfer(8'h54, ack);
            end
            wt(5);
        join
        check("wake ack", {7'h0, ack}, 8'h01);
        tws_bfm_i.stop();
        low_power <= 1'b0;
        $display("low power test done");
        wr(5'h0c, 8'h01);
        wt(6);
        n = 0;
        while (scl_oe_n !== 1'b0 && ++n < LIM)
            @(negedge aclk);
        check("start hold", n[7:0], 8'h10);
        if (n >= LIM) tally_and_finish();
        rdc(5'h04, 8'h43);
        wr(5'h0c, 8'h02);
        repeat (100) @(posedge aclk);
        rdc(5'h04, 8'h40);
        $display("master test done");
        check("bus stall", tws_bfm_i.hung[7:0], 8'h00);
        tally_and_finish();
    end
endmodule // tws_unit_tb_top
